// ### verilog/device_config.sv
// Device configuration registers on APB and shared-pin routing.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps

module device_config #(
  parameter int  PAIRS      = cfg_pkg::PAIR_PINS,
  parameter int  TRIPLES    = cfg_pkg::TRIPLE_PINS,
  parameter bit  HAS_AUDIO2 = 1'b1
) (
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  input  wire logic [cfg_pkg::CAP_W-1:0] strap0_i,
  input  wire logic [cfg_pkg::CAP_W-1:0] strap1_i,
  output logic                   host_enable_o,
  output logic                   host_nonmultiplexed_host_mode_o,
  output logic                   host_addr_apply_o,
  output logic [15:0]            host_addr_upper_o,
  input  wire logic [cfg_pkg::DMA_EVT_N-1:0] audio_dma_evt_i,
  output logic [1:0]             timer_capture_o,
  output logic [2:0]             audio_mute_input_o,
  output logic                   bridge_reset_o,
  input  wire logic [2*PAIRS-1:0] pair_oe_i,
  input  wire logic [2*PAIRS-1:0] pair_out_i,
  input  wire logic [PAIRS-1:0]  pair_pad_in_i,
  output logic      [PAIRS-1:0]  pair_pad_oe_o,
  output logic      [PAIRS-1:0]  pair_pad_out_o,
  output logic      [PAIRS-1:0]  pair_in_o,
  input  wire logic [3*TRIPLES-1:0] tri_oe_i,
  input  wire logic [3*TRIPLES-1:0] tri_out_i,
  input  wire logic [TRIPLES-1:0] tri_pad_in_i,
  output logic      [TRIPLES-1:0] tri_pad_oe_o,
  output logic      [TRIPLES-1:0] tri_pad_out_o,
  output logic      [TRIPLES-1:0] tri_in_o,
  input  wire logic [cfg_pkg::EM_PINS-1:0] mem_oe_i,
  input  wire logic [cfg_pkg::EM_PINS-1:0] mem_out_i,
  input  wire logic [cfg_pkg::EM_PINS-1:0] mem_pad_in_i,
  output logic      [cfg_pkg::EM_PINS-1:0] mem_pad_oe_o,
  output logic      [cfg_pkg::EM_PINS-1:0] mem_pad_out_o,
  output logic      [cfg_pkg::EM_PINS-1:0] host_address_inputs_o
);
  import cfg_pkg::*;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Picks one DMA event; codes past the last event give zero.
  function automatic logic pick_evt(
    input logic [DMA_EVT_N-1:0] evt,
    input logic [TMR_SEL_W-1:0] sel
  );
    logic r;
    r = 1'b0;
    if (int'(sel) < DMA_EVT_N) begin
      r = evt[sel];
    end
    return r;
  endfunction

  // Picks one shared pin level; codes past the last pin give zero.
  function automatic logic pick_pin(
    input logic [PAIRS-1:0]      pins,
    input logic [MUTE_SEL_W-1:0] sel
  );
    logic r;
    r = 1'b0;
    if (int'(sel) < PAIRS) begin
      r = pins[sel];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [CAP_W-1:0]      pin_capture_0;
  logic [CAP_W-1:0]      pin_capture_1;
  logic                  cap_done;
  logic [2*CAP_W-1:0]    strap_s1;
  logic [2*CAP_W-1:0]    strap_s2;
  logic [2*CAP_W-1:0]    strap_s3;
  logic [HOST_CFG_W-1:0] host_port_config;
  logic [HADDR_W-1:0]    host_addr_top_byte;
  logic [HADDR_W-1:0]    host_addr_upper_mid_byte;
  logic [7:0]            timer_capture_source;
  logic [MUTE_SEL_W-1:0] audio0_mute_select;
  logic [MUTE_SEL_W-1:0] audio1_mute_select;
  logic [MUTE_SEL_W-1:0] audio2_mute_select;
  logic                  bus_bridge_reset;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic        setup;
  logic        wr;
  logic        hit_cap0;
  logic        hit_cap1;
  logic        hit_host;
  logic        hit_top;
  logic        hit_umid;
  logic        hit_tmr;
  logic        hit_m0;
  logic        hit_m1;
  logic        hit_m2;
  logic        hit_brg;
  logic        hit_any;
  logic [31:0] rdata;

  // Address match per register and the phase strobes.
  assign setup    = psel_i & ~penable_i;
  assign wr       = psel_i & penable_i & pready_o & pwrite_i;
  assign hit_cap0 = paddr_i == PIN_CAP0_ADDR;
  assign hit_cap1 = paddr_i == PIN_CAP1_ADDR;
  assign hit_host = paddr_i == HOST_CFG_ADDR;
  assign hit_top  = paddr_i == HADDR_TOP_ADDR;
  assign hit_umid = paddr_i == HADDR_UMID_ADDR;
  assign hit_tmr  = paddr_i == TMR_SRC_ADDR;
  assign hit_m0   = paddr_i == MUTE0_ADDR;
  assign hit_m1   = paddr_i == MUTE1_ADDR;
  assign hit_m2   = paddr_i == MUTE2_ADDR;
  assign hit_brg  = paddr_i == BRIDGE_ADDR;
  assign hit_any  = hit_cap0 | hit_cap1 | hit_host | hit_top |
                    hit_umid | hit_tmr | hit_m0 | hit_m1 |
                    hit_m2 | hit_brg;

  // Read data; unused bits and the reserved mute register read zero.
  assign rdata =
    hit_cap0 ? {24'h000000, pin_capture_0} :
    hit_cap1 ? {24'h000000, pin_capture_1} :
    hit_host ? {29'h0, host_port_config} :
    hit_top  ? {24'h000000, host_addr_top_byte} :
    hit_umid ? {24'h000000, host_addr_upper_mid_byte} :
    hit_tmr  ? {24'h000000, timer_capture_source} :
    hit_m0   ? {27'h0, audio0_mute_select} :
    hit_m1   ? {27'h0, audio1_mute_select} :
    hit_m2   ? {27'h0, audio2_mute_select} :
    hit_brg  ? {31'h0, bus_bridge_reset} :
    32'h00000000;

  // Zero-wait answer: pready rises in the first access cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      prdata_o  <= setup & ~pwrite_i ? rdata : 32'h00000000;
      pslverr_o <= setup & ~hit_any;
    end
  end

  // ---------------------------------------------------------------
  // Strap capture at reset release
  // ---------------------------------------------------------------

  // Strap pins are asynchronous and pass three stages.
  always_ff @(posedge clk_sys_i) begin
    strap_s1 <= {strap1_i, strap0_i};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // Latches the settled strap levels once after each reset.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cap_done      <= 1'b0;
      pin_capture_0 <= '0;
      pin_capture_1 <= '0;
    end else if (!cap_done && strap_s2 == strap_s3) begin
      cap_done      <= 1'b1;
      pin_capture_0 <= strap_s3[CAP_W-1:0];
      pin_capture_1 <= strap_s3[2*CAP_W-1:CAP_W];
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------

  logic [7:0] tmr_wdata;

  // Keeps only the two select fields, so the spare bits read back zero.
  always_comb begin
    tmr_wdata = 8'h00;
    tmr_wdata[TMR_SEL0_LSB+:TMR_SEL_W] = pwdata_i[TMR_SEL0_LSB+:TMR_SEL_W];
    tmr_wdata[TMR_SEL1_LSB+:TMR_SEL_W] = pwdata_i[TMR_SEL1_LSB+:TMR_SEL_W];
  end

  // Software writes take effect at the access edge with pready high.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      host_port_config         <= HOST_CFG_RST;
      host_addr_top_byte       <= HADDR_RST;
      host_addr_upper_mid_byte <= HADDR_RST;
      timer_capture_source     <= TMR_SRC_RST;
      audio0_mute_select       <= MUTE_SEL_RST;
      audio1_mute_select       <= MUTE_SEL_RST;
      audio2_mute_select       <= MUTE_SEL_RST;
      bus_bridge_reset         <= BRIDGE_RST;
    end else if (wr) begin
      if (hit_host) begin
        host_port_config <= pwdata_i[HOST_CFG_W-1:0];
      end
      if (hit_top) begin
        host_addr_top_byte <= pwdata_i[HADDR_W-1:0];
      end
      if (hit_umid) begin
        host_addr_upper_mid_byte <= pwdata_i[HADDR_W-1:0];
      end
      if (hit_tmr) begin
        timer_capture_source <= tmr_wdata;
      end
      if (hit_m0) begin
        audio0_mute_select <= pwdata_i[MUTE_SEL_W-1:0];
      end
      if (hit_m1) begin
        audio1_mute_select <= pwdata_i[MUTE_SEL_W-1:0];
      end
      if (hit_m2 && HAS_AUDIO2) begin
        audio2_mute_select <= pwdata_i[MUTE_SEL_W-1:0];
      end
      if (hit_brg) begin
        bus_bridge_reset <= pwdata_i[BRIDGE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  logic [TMR_SEL_W-1:0] tmr_sel0;
  logic [TMR_SEL_W-1:0] tmr_sel1;
  logic                 addr_apply;

  // Field slices and the upper-address apply condition.
  assign tmr_sel0   = timer_capture_source[TMR_SEL0_LSB+:TMR_SEL_W];
  assign tmr_sel1   = timer_capture_source[TMR_SEL1_LSB+:TMR_SEL_W];
  assign addr_apply = host_port_config[HOST_NONMULTIPLEXED_HOST_MODE_BIT] |
                      host_port_config[HOST_RESTR_BIT];

  // Registered configuration copies and the picked DMA events and mute pin levels for the peripherals.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      host_enable_o      <= 1'b0;
      host_nonmultiplexed_host_mode_o        <= 1'b0;
      host_addr_apply_o  <= 1'b0;
      host_addr_upper_o  <= 16'h0000;
      timer_capture_o    <= 2'h0;
      audio_mute_input_o <= 3'h0;
      bridge_reset_o     <= 1'b0;
    end else begin
      host_enable_o <= host_port_config[HOST_EN_BIT];
      host_nonmultiplexed_host_mode_o   <= host_port_config[HOST_NONMULTIPLEXED_HOST_MODE_BIT];
      host_addr_apply_o <= addr_apply;
      host_addr_upper_o <= {host_addr_top_byte,
                            host_addr_upper_mid_byte};
      timer_capture_o[0] <= pick_evt(audio_dma_evt_i, tmr_sel0);
      timer_capture_o[1] <= pick_evt(audio_dma_evt_i, tmr_sel1);
      audio_mute_input_o[0] <= pick_pin(pair_in_o,
                                        audio0_mute_select);
      audio_mute_input_o[1] <= pick_pin(pair_in_o,
                                        audio1_mute_select);
      audio_mute_input_o[2] <= HAS_AUDIO2 &
        pick_pin(pair_in_o, audio2_mute_select);
      bridge_reset_o <= bus_bridge_reset;
    end
  end

  // ---------------------------------------------------------------
  // Shared pins
  // ---------------------------------------------------------------
  logic [EM_PINS-1:0] mem_oe_gated;

  // Memory data drive is blocked while non-muxed host mode is set.
  assign mem_oe_gated = host_port_config[HOST_NONMULTIPLEXED_HOST_MODE_BIT] ?
                        '0 : mem_oe_i;

  // Two-sharer pins: serial 0 over two-wire, audio 0 over the other
  // port; sharers pick function and direction themselves.
  pin_share #(
    .W (PAIRS),
    .N (2)
  ) u_pairs (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .per_oe_i  (pair_oe_i),
    .per_out_i (pair_out_i),
    .pad_in_i  (pair_pad_in_i),
    .pad_oe_o  (pair_pad_oe_o),
    .pad_out_o (pair_pad_out_o),
    .pin_in_o  (pair_in_o)
  );

  // Three-sharer pins: audio 0, then audio 1, then serial port 1.
  pin_share #(
    .W (TRIPLES),
    .N (3)
  ) u_triples (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .per_oe_i  (tri_oe_i),
    .per_out_i (tri_out_i),
    .pad_in_i  (tri_pad_in_i),
    .pad_oe_o  (tri_pad_oe_o),
    .pad_out_o (tri_pad_out_o),
    .pin_in_o  (tri_in_o)
  );

  // Upper memory data pins double as host address inputs.
  pin_share #(
    .W (EM_PINS),
    .N (1)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .per_oe_i  (mem_oe_gated),
    .per_out_i (mem_out_i),
    .pad_in_i  (mem_pad_in_i),
    .pad_oe_o  (mem_pad_oe_o),
    .pad_out_o (mem_pad_out_o),
    .pin_in_o  (host_address_inputs_o)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence apb_setup_s;
    psel_i && !penable_i;
  endsequence

  sequence apb_miss_s;
    apb_setup_s and !hit_any;
  endsequence

  apb_ready_a: assert property (apb_setup_s |=> pready_o)
    else $error("No ready in the first access cycle.");
  apb_error_a: assert property (apb_miss_s |=> pslverr_o)
    else $error("Unmapped address not flagged.");
  strap_hold_a: assert property (
    cap_done && $past(cap_done) |-> $stable(pin_capture_0))
    else $error("Strap capture changed after latching.");
  nonmultiplexed_host_mode_block_a: assert property (
    host_port_config[HOST_NONMULTIPLEXED_HOST_MODE_BIT] |=> mem_pad_oe_o == '0)
    else $error("Memory data driven in non-muxed mode.");
  addr_apply_a: assert property (
    addr_apply |=> host_addr_apply_o)
    else $error("Upper address bytes not applied.");
  tmr_pick_a: assert property (
    int'(tmr_sel0) < DMA_EVT_N |=>
      timer_capture_o[0] == $past(audio_dma_evt_i[tmr_sel0]))
    else $error("Wrong DMA event on capture channel.");
  mute_pick_a: assert property (
    int'(audio0_mute_select) < PAIRS |=>
      audio_mute_input_o[0] == $past(pair_in_o[audio0_mute_select]))
    else $error("Wrong pin on audio 0 mute input.");
  mute2_res_a: assert property (
    int'(audio2_mute_select) < PAIRS |=> audio_mute_input_o[2] ==
      (HAS_AUDIO2 && $past(pair_in_o[audio2_mute_select])))
    else $error("Audio 2 mute input wrong or not held reserved.");
  bridge_wr_a: assert property (
    wr && hit_brg && pwdata_i[BRIDGE_BIT] |=> ##1 bridge_reset_o)
    else $error("Bridge reset not asserted after write.");
  host_en_a: assert property (
    wr && hit_host |=> ##1
      host_enable_o == $past(pwdata_i[HOST_EN_BIT], 2))
    else $error("Host enable does not follow its write.");

endmodule

// ### verilog/cfg_pkg.sv
// Constants of the device configuration and shared-pin block.
package cfg_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] PIN_CAP0_ADDR   = 32'h40000000;
  localparam logic [31:0] PIN_CAP1_ADDR   = 32'h40000004;
  localparam logic [31:0] HOST_CFG_ADDR   = 32'h40000008;
  localparam logic [31:0] HADDR_TOP_ADDR  = 32'h4000000C;
  localparam logic [31:0] HADDR_UMID_ADDR = 32'h40000010;
  localparam logic [31:0] TMR_SRC_ADDR    = 32'h40000014;
  localparam logic [31:0] MUTE0_ADDR      = 32'h40000018;
  localparam logic [31:0] MUTE1_ADDR      = 32'h4000001C;
  localparam logic [31:0] MUTE2_ADDR      = 32'h40000020;
  localparam logic [31:0] BRIDGE_ADDR     = 32'h40000024;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int CAP_W        = 8;
  localparam int HOST_EN_BIT  = 0;
  localparam int HOST_NONMULTIPLEXED_HOST_MODE_BIT = 1;
  localparam int HOST_RESTR_BIT = 2;
  localparam int HOST_CFG_W   = 3;
  localparam int HADDR_W      = 8;
  localparam int TMR_SEL_W    = 3;
  localparam int TMR_SEL0_LSB = 0;
  localparam int TMR_SEL1_LSB = 4;
  localparam int DMA_EVT_N    = 6;
  localparam int MUTE_SEL_W   = 5;
  localparam int BRIDGE_BIT   = 0;

  // ---------------------------------------------------------------
  // Reset values and pin group sizes
  // ---------------------------------------------------------------
  localparam logic [HOST_CFG_W-1:0] HOST_CFG_RST = 3'h0;
  localparam logic [HADDR_W-1:0]    HADDR_RST    = 8'h00;
  localparam logic [7:0]            TMR_SRC_RST  = 8'h00;
  localparam logic [MUTE_SEL_W-1:0] MUTE_SEL_RST = 5'h00;
  localparam logic                  BRIDGE_RST   = 1'b0;
  localparam int PAIR_PINS   = 17;
  localparam int TRIPLE_PINS = 2;
  localparam int EM_PINS     = 16;

endpackage

// ### verilog/pin_share.sv
// Shared pad group: enable merge, priority data and input broadcast.
`timescale 1ns/100ps
module pin_share #(
  parameter int W = 1,
  parameter int N = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic [N*W-1:0] per_oe_i,
  input  wire logic [N*W-1:0] per_out_i,
  input  wire logic [W-1:0] pad_in_i,
  output logic      [W-1:0] pad_oe_o,
  output logic      [W-1:0] pad_out_o,
  output logic      [W-1:0] pin_in_o
);

  logic [W-1:0] next_oe;
  logic [W-1:0] next_out;
  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic [W-1:0] next_in;

  // Sharer n of pin w sits at n*W+w; sharer 0 has top priority.
  always_comb begin
    next_oe  = '0;
    next_out = '0;
    for (int w = 0; w < W; w++) begin
      for (int n = N - 1; n >= 0; n--) begin
        if (per_oe_i[n*W+w]) begin
          next_oe[w]  = 1'b1;
          next_out[w] = per_out_i[n*W+w];
        end
      end
    end
  end

  // A pad bit changes once the last two sync stages agree.
  assign next_in = (sync2 & sync3) | (pin_in_o & (sync2 ^ sync3));

  // Three-stage synchroniser for the pad levels.
  always_ff @(posedge clk_sys_i) begin
    sync1 <= pad_in_i;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // Registered pad drive and broadcast input.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pad_oe_o  <= '0;
      pad_out_o <= '0;
      pin_in_o  <= '0;
    end else begin
      pad_oe_o  <= next_oe;
      pad_out_o <= next_out;
      pin_in_o  <= next_in;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  any_enable_a: assert property (|per_oe_i |=> |pad_oe_o)
    else $error("Pad enable missing while a sharer drives.");
  first_wins_a: assert property (
    per_oe_i[0] |=> pad_out_o[0] == $past(per_out_i[0]))
    else $error("Top priority sharer does not own the pad.");
  input_agree_a: assert property (
    (sync2[0] == sync3[0]) |=> pin_in_o[0] == $past(sync3[0]))
    else $error("Broadcast input does not follow the pad.");

endmodule

// ### test/pin_sharers.sv
// Model of the peripherals that share the device pins.
`timescale 1ns/100ps
module pin_sharers (
  input  wire logic        clk_sys_i,
  input  wire logic [1:0]  mode_i,
  output logic      [33:0] pair_oe_o,
  output logic      [33:0] pair_out_o,
  output logic      [5:0]  tri_oe_o,
  output logic      [5:0]  tri_out_o,
  output logic      [15:0] mem_oe_o,
  output logic      [15:0] mem_out_o
);
  // Each sharer sets its own direction; mode 1 has only the lowest
  // priority sharer driving, mode 2 has every sharer driving.
  assign pair_oe_o = (mode_i == 2'h2) ? {34{1'b1}} :
    (mode_i == 2'h1) ? {{17{1'b1}}, 17'h00000} : 34'h0;
  assign tri_oe_o = (mode_i == 2'h2) ? 6'h3F :
    (mode_i == 2'h1) ? 6'h30 : 6'h00;
  assign mem_oe_o = (mode_i != 2'h0) ? 16'hFFFF : 16'h0000;

  // Data of a sharer that does not drive toggles every cycle.
  initial begin
    pair_out_o = 34'h0;
    tri_out_o = 6'h00;
    mem_out_o = 16'h0000;
  end
  always @(posedge clk_sys_i) begin
    pair_out_o <= (pair_oe_o & {17'h15A5A, 17'h0A5A5}) |
      (~pair_oe_o & ~pair_out_o);
    tri_out_o <= (tri_oe_o & 6'h39) | (~tri_oe_o & ~tri_out_o);
    mem_out_o <= (mem_oe_o & 16'hC3A5) | (~mem_oe_o & ~mem_out_o);
  end
endmodule

// ### test/tb_device_config.sv
// Self-checking bench of the configuration and shared-pin block.
`timescale 1ns/100ps
module tb_device_config;
  import cfg_pkg::*;
  logic        clk_sys_i, resetn_i, psel, penable, pwrite, pready;
  logic        pslverr, host_en, host_nonmultiplexed_host_mode, host_apply, bridge, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] host_upper, m_oe, m_out, mp_in, mp_oe, mp_out, h_addr;
  logic [7:0]  strap0, strap1;
  logic [5:0]  dma_evt, t_oe, t_out;
  logic [2:0]  mute_in;
  logic [1:0]  tmr_cap, mode, tp_in, tp_oe, tp_out, t_in;
  logic [33:0] p_oe, p_out;
  logic [16:0] pp_in, pp_oe, pp_out, p_in;
  int          n_mismatch, n_checks, cyc;
  logic [31:0] r_addr [11] = '{PIN_CAP0_ADDR, PIN_CAP1_ADDR,
    HOST_CFG_ADDR, HADDR_TOP_ADDR, HADDR_UMID_ADDR, TMR_SRC_ADDR,
    MUTE0_ADDR, MUTE1_ADDR, MUTE2_ADDR, BRIDGE_ADDR, 32'h40000028};
  logic [31:0] r_wr [11] = '{32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'h12345678, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3,
    32'h4, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [31:0] r_rst [11] = '{32'hA5, 32'h3C, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] r_rd [11] = '{32'hA5, 32'h3C, 32'h7, 32'hFF, 32'h78,
    32'h77, 32'h1F, 32'h3, 32'h4, 32'h1, 32'h0};

  device_config uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .strap0_i(strap0),
    .strap1_i(strap1), .host_enable_o(host_en), .host_nonmultiplexed_host_mode_o(host_nonmultiplexed_host_mode),
    .host_addr_apply_o(host_apply), .host_addr_upper_o(host_upper),
    .audio_dma_evt_i(dma_evt), .timer_capture_o(tmr_cap),
    .audio_mute_input_o(mute_in), .bridge_reset_o(bridge),
    .pair_oe_i(p_oe), .pair_out_i(p_out), .pair_pad_in_i(pp_in),
    .pair_pad_oe_o(pp_oe), .pair_pad_out_o(pp_out), .pair_in_o(p_in),
    .tri_oe_i(t_oe), .tri_out_i(t_out), .tri_pad_in_i(tp_in),
    .tri_pad_oe_o(tp_oe), .tri_pad_out_o(tp_out), .tri_in_o(t_in),
    .mem_oe_i(m_oe), .mem_out_i(m_out), .mem_pad_in_i(mp_in),
    .mem_pad_oe_o(mp_oe), .mem_pad_out_o(mp_out),
    .host_address_inputs_o(h_addr));

  pin_sharers model (.clk_sys_i(clk_sys_i), .mode_i(mode),
    .pair_oe_o(p_oe), .pair_out_o(p_out), .tri_oe_o(t_oe),
    .tri_out_o(t_out), .mem_oe_o(m_oe), .mem_out_o(m_out));

  // Clock of 100 ns period.
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tmr(input logic [5:0] e, input logic [1:0] x);
    dma_evt <= e;
    repeat (3) @(posedge clk_sys_i);
    check("timer capture", tmr_cap, x);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: register table, then outputs, pins and reset.
  initial begin
    {resetn_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {dma_evt, pp_in, tp_in, mp_in, mode} = '0;
    strap0 = 8'hA5;
    strap1 = 8'h3C;
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, r_addr[i], 32'h0);
      check("reset value", rd, r_rst[i]);
      apb(1'b1, r_addr[i], r_wr[i]);
      apb(1'b0, r_addr[i], 32'h0);
      check("read back", rd, r_rd[i]);
      check("slave error", er, r_err(i));
    end
    repeat (2) @(posedge clk_sys_i);
    check("host outputs", {host_en, host_nonmultiplexed_host_mode, host_apply}, 3'h7);
    check("host address", host_upper, 16'hFF78);
    check("bridge on", bridge, 1'b1);
    apb(1'b1, BRIDGE_ADDR, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    check("bridge off", bridge, 1'b0);
    apb(1'b1, TMR_SRC_ADDR, 32'h52);
    tmr(6'h04, 2'h1);
    tmr(6'h20, 2'h2);
    tmr(6'h24, 2'h3);
    apb(1'b1, TMR_SRC_ADDR, 32'h66);
    tmr(6'h3F, 2'h0);
    apb(1'b1, MUTE0_ADDR, 32'h4);
    apb(1'b1, MUTE1_ADDR, 32'h10);
    pp_in <= 17'h10010;
    repeat (6) @(posedge clk_sys_i);
    check("mute high", mute_in, 3'h7);
    pp_in <= 17'h0;
    repeat (6) @(posedge clk_sys_i);
    check("mute low", mute_in, 3'h0);
    for (int nm = 1; nm >= 0; nm--) begin
      apb(1'b1, HOST_CFG_ADDR, {30'h0, nm[0], 1'b1});
      for (int m = 0; m < 3; m++) begin
        mode <= m[1:0];
        pp_in <= 17'h1E0F1 ^ m[16:0];
        tp_in <= m[1:0];
        mp_in <= 16'h5A00 | m[15:0];
        repeat (6) @(posedge clk_sys_i);
        check("pair oe", pp_oe, m > 0 ? 17'h1FFFF : 17'h0);
        check("tri oe", tp_oe, m > 0 ? 2'h3 : 2'h0);
        check("mem oe", mp_oe, (m > 0 && nm == 0) ? 16'hFFFF : 16'h0);
        if (m > 0) begin
          check("pair out", pp_out, m == 2 ? 17'h0A5A5 : 17'h15A5A);
          check("tri out", tp_out, m == 2 ? 2'h1 : 2'h3);
        end
        if (m > 0 && nm == 0) check("mem out", mp_out, 16'hC3A5);
        check("pair in", p_in, 17'h1E0F1 ^ m[16:0]);
        check("tri in", t_in, m[1:0]);
        check("host addr in", h_addr, 16'h5A00 | m[15:0]);
      end
    end
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check("outputs in reset", {host_en, pp_oe}, 18'h0);
    resetn_i <= 1'b1;
    apb(1'b0, HOST_CFG_ADDR, 32'h0);
    check("config after reset", rd, 32'h0);
    report_and_stop();
  end

  function automatic logic r_err(input int i);
    return (i == 10);
  endfunction
endmodule
